// *** common/sau_pkg.sv ***
/*
 * Shared constants and types for the stack and operand address unit.
 * Assumes a single core clock and a 9-bit wide internal data RAM.
 */
package sau_pkg;

  // ---------------------------------------------------------------
  // Register map and memory areas
  // ---------------------------------------------------------------
  localparam logic [15:0] SP_LOW_ADDR  = 16'hFE0A;
  localparam logic [15:0] SP_HIGH_ADDR = 16'hFE0B;
  localparam logic [15:0] SP_RST       = 16'h0000;
  localparam logic [15:0] SP_STEP      = 16'h0001;
  localparam logic [15:0] RAM_TOP      = 16'hFDFF;
  localparam logic [7:0]  SFR_PAGE     = 8'hFE;
  localparam logic [7:0]  RAM_PAGE0    = 8'h00;
  localparam logic [7:0]  BLANK_BYTE   = 8'hFF;
  localparam logic [7:0]  RD_ZERO      = 8'h00;
  localparam logic [16:0] ROM_STEP     = 17'h0_0001;

  // ---------------------------------------------------------------
  // Operations and address modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PUSH    = 3'b000,
    OP_POP     = 3'b001,
    OP_CALL    = 3'b010,
    OP_RET     = 3'b011,
    OP_OPERAND = 3'b100,
    OP_TABLE   = 3'b101,
    OP_EXT     = 3'b110
  } sau_op_t;

  typedef enum logic [2:0] {
    MD_IMM8     = 3'b000,
    MD_IMM16    = 3'b001,
    MD_PTR      = 3'b010,
    MD_PTR_C    = 3'b011,
    MD_OFF      = 3'b100,
    MD_DIRECT   = 3'b101,
    MD_DIRECT_L = 3'b110
  } sau_mode_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    sau_op_t    op;
    sau_mode_t  mode;
    logic [5:0] ptr_idx;
    logic [6:0] off7;
    logic [15:0] opnd;
    logic [8:0] push_data;
    logic [16:0] pc;
    logic       bank;
  } sau_req_t;

  typedef struct packed {
    logic [7:0] breg;
    logic [7:0] creg;
    logic       tbl_bank;
  } sau_core_t;

  typedef struct packed {
    logic        re;
    logic        we;
    logic [15:0] addr;
    logic [8:0]  wdata;
  } sau_mem_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        blank;
    logic [15:0] imm;
    logic [8:0]  data;
    logic [16:0] ret_pc;
    logic        ret_bank;
    logic [7:0]  tbl_acc;
    logic [7:0]  tbl_b;
  } sau_res_t;

endpackage : sau_pkg

// *** design/sau_stack_ptr.sv ***
/*
 * Stack pointer register pair with its data-space write port.
 * Assumes the sequencer never steps the pointer and writes it at once.
 */
module sau_stack_ptr (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        inc_i,
  input  wire logic        dec_i,
  input  wire logic        sfr_we_i,
  input  wire logic [15:0] sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [15:0] sp_o
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic wr_lo = sfr_we_i && (sfr_addr_i == sau_pkg::SP_LOW_ADDR);
  wire logic wr_hi = sfr_we_i && (sfr_addr_i == sau_pkg::SP_HIGH_ADDR);
  wire logic [15:0] sp_nxt = inc_i ? sp_o + sau_pkg::SP_STEP :
                             dec_i ? sp_o - sau_pkg::SP_STEP :
                             {wr_hi ? sfr_wdata_i : sp_o[15:8],
                              wr_lo ? sfr_wdata_i : sp_o[7:0]};

  // Pointer register, cleared on reset
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) sp_o <= sau_pkg::SP_RST;
    else sp_o <= sp_nxt;
  end

  AST_SP_RESET: assert property (@(posedge clk_sys_i)
    $past(!rstn_i) && rstn_i |-> sp_o == sau_pkg::SP_RST)
    else $error("stack pointer not zero after reset");

endmodule : sau_stack_ptr

// *** design/sau_area_calc.sv ***
/*
 * Base plus signed offset; register pages wrap in their page, RAM overruns are flagged blank.
 * Purely combinational; the caller registers the result.
 */
module sau_area_calc (
  input  wire logic [15:0] base_i,
  input  wire logic [7:0]  off_i,
  output logic      [15:0] sum_o,
  output logic      [15:0] addr_o,
  output logic             blank_o
);

  // ---------------------------------------------------------------
  // Area confinement
  // ---------------------------------------------------------------
  wire logic base_ram = base_i <= sau_pkg::RAM_TOP;
  assign sum_o   = base_i + {{8{off_i[7]}}, off_i};
  // Leaving general RAM reads as blank; negatives wrap above it
  assign blank_o = base_ram && (sum_o > sau_pkg::RAM_TOP);
  // Register and reserved pages wrap within their own 256 bytes
  assign addr_o  = base_ram ? sum_o : {base_i[15:8], sum_o[7:0]};

endmodule : sau_area_calc

// *** design/sau_top.sv ***
/*
 * Stack and operand address unit: stack pointer, return-address
 * save and restore, and operand, table and external addresses.
 * Assumes a synchronous data RAM and program ROM whose read data is
 * valid in the cycle after the read strobe is high, and a sequencer
 * that holds a request until it is taken while busy_o is low.
 */
// Function
// - Stack pointer: two bytes at FE0A, FE0B
// - Reset clears the whole stack pointer
// - Increment before save, decrement after restore
// - Stack lives in general RAM; pushes past FDFF are not written, yet the pointer still steps
// - Call pushes bank+low byte, then high
// - Return pops high, then bank+low byte
// - Bank+low at SP+1, high nine at SP+2
// - Sixty-four pointer registers in low RAM
// - Pointer n: low at 2n, high 2n+1
// - Pointer mode uses full pointer contents
// - Pointer plus signed C register
// - Pointer zero plus seven-bit signed offset
// - Operand offsets stay in the base area except RAM overruns (flagged blank) and external addresses
// - RAM overrun reads back FF
// - Register page wraps within its page
// - Byte or word immediate from instruction
// - Direct address, short and long forms
// - Word table read via pointer forms
// - Table pointer widened to seventeen bits
// - Seventeenth bit is high byte's ninth bit
// - Table bank flag picks program bank
// - Bank zero low half, one upper half
// - Accumulator gets first byte, B next
// - External address: B over sixteen bits
module sau_top (
  input  wire logic               clk_sys_i,
  input  wire logic               rstn_i,
  input  wire logic               req_valid_i,
  input  wire sau_pkg::sau_req_t  req_i,
  input  wire sau_pkg::sau_core_t core_i,
  input  wire logic [8:0]         mem_rdata_i,
  input  wire logic [7:0]         rom_rdata_i,
  input  wire logic               sfr_we_i,
  input  wire logic [15:0]        sfr_addr_i,
  input  wire logic [7:0]         sfr_wdata_i,
  output sau_pkg::sau_mem_t       mem_o,
  output logic                    rom_re_o,
  output logic [17:0]             rom_addr_o,
  output logic [7:0]              sfr_rdata_o,
  output logic                    sfr_hit_o,
  output sau_pkg::sau_res_t       res_o,
  output logic                    busy_o,
  output logic                    done_o,
  output logic                    stack_err_o
);

  // ---------------------------------------------------------------
  // State encoding
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_POP1  = 4'b0001,
    S_POP2  = 4'b0010,
    S_CALL2 = 4'b0011,
    S_RET1  = 4'b0100,
    S_RET2  = 4'b0101,
    S_RET3  = 4'b0110,
    S_PTR1  = 4'b0111,
    S_PTR2  = 4'b1000,
    S_PTR3  = 4'b1001,
    S_CALC  = 4'b1010,
    S_ROM1  = 4'b1011,
    S_ROM2  = 4'b1100,
    S_ROM3  = 4'b1101
  } sau_state_t;

  sau_state_t         state_r;
  sau_pkg::sau_req_t  req_r;
  sau_pkg::sau_core_t core_r;
  logic [15:0]        ptr_r;
  logic               ptr_n9_r;
  logic [15:0]        sp;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  wire logic take     = (state_r == S_IDLE) && req_valid_i;
  wire logic take_psh = take && (req_i.op == sau_pkg::OP_PUSH);
  wire logic take_pop = take && (req_i.op == sau_pkg::OP_POP);
  wire logic take_cal = take && (req_i.op == sau_pkg::OP_CALL);
  wire logic take_ret = take && (req_i.op == sau_pkg::OP_RET);
  wire logic mode_ptr = (req_i.mode == sau_pkg::MD_PTR) ||
                        (req_i.mode == sau_pkg::MD_PTR_C) ||
                        (req_i.mode == sau_pkg::MD_OFF);
  wire logic take_ptr = take && mode_ptr &&
                        ((req_i.op == sau_pkg::OP_OPERAND) ||
                         (req_i.op == sau_pkg::OP_TABLE) ||
                         (req_i.op == sau_pkg::OP_EXT));
  wire logic take_now = take && !mode_ptr &&
                        (req_i.op == sau_pkg::OP_OPERAND);
  // Short-offset mode always works from pointer zero
  wire logic [5:0] idx = (req_i.mode == sau_pkg::MD_OFF) ?
                         6'h00 : req_i.ptr_idx;
  wire logic [15:0] ptr_lo_a = {9'h000, idx, 1'b0};
  wire logic [15:0] ptr_hi_a = {9'h000, req_r.ptr_idx, 1'b1} &
                               {15'h7FFF & {15{req_r.mode !=
                               sau_pkg::MD_OFF}}, 1'b1};

  // ---------------------------------------------------------------
  // Stack addresses
  // ---------------------------------------------------------------
  wire logic [15:0] sp_p1 = sp + sau_pkg::SP_STEP;
  wire logic [15:0] sp_m1 = sp - sau_pkg::SP_STEP;
  wire logic sp_inc = take_psh || take_cal || (state_r == S_CALL2);
  wire logic sp_dec = (state_r == S_POP2) || (state_r == S_RET2) ||
                      (state_r == S_RET3);
  wire logic push_bad = sp_p1 > sau_pkg::RAM_TOP;
  wire logic pop_bad  = sp > sau_pkg::RAM_TOP;

  // ---------------------------------------------------------------
  // Direct and immediate operands
  // ---------------------------------------------------------------
  wire logic [15:0] dir_a = (req_i.mode == sau_pkg::MD_DIRECT_L) ?
      req_i.opnd :
      {req_i.opnd[8] ? sau_pkg::SFR_PAGE : sau_pkg::RAM_PAGE0,
       req_i.opnd[7:0]};
  wire logic [15:0] imm_v = (req_i.mode == sau_pkg::MD_IMM8) ?
      {sau_pkg::RD_ZERO, req_i.opnd[7:0]} : req_i.opnd;

  // ---------------------------------------------------------------
  // Offset selection and area arithmetic
  // ---------------------------------------------------------------
  wire logic [7:0] off8 =
      (req_r.mode == sau_pkg::MD_PTR_C) ? core_r.creg :
      (req_r.mode == sau_pkg::MD_OFF) ?
      {req_r.off7[6], req_r.off7} : sau_pkg::RD_ZERO;
  logic [15:0] sum_a;
  logic [15:0] conf_a;
  logic        blank;

  sau_area_calc u_area (
    .base_i  (ptr_r),
    .off_i   (off8),
    .sum_o   (sum_a),
    .addr_o  (conf_a),
    .blank_o (blank)
  );

  // Table address: ninth bit on top, then bank flag above
  wire logic [16:0] tbl_a = {ptr_n9_r, ptr_r} +
                            {{9{off8[7]}}, off8};
  wire logic [17:0] rom_a = {core_r.tbl_bank, tbl_a};

  // ---------------------------------------------------------------
  // Stack pointer
  // ---------------------------------------------------------------
  sau_stack_ptr u_sp (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .inc_i       (sp_inc),
    .dec_i       (sp_dec),
    .sfr_we_i    (sfr_we_i),
    .sfr_addr_i  (sfr_addr_i),
    .sfr_wdata_i (sfr_wdata_i),
    .sp_o        (sp)
  );

  // Stack pointer bytes read back in the data space
  wire logic rd_lo = sfr_addr_i == sau_pkg::SP_LOW_ADDR;
  wire logic rd_hi = sfr_addr_i == sau_pkg::SP_HIGH_ADDR;
  wire logic [7:0] sfr_rd = rd_lo ? sp[7:0] :
                            rd_hi ? sp[15:8] : sau_pkg::RD_ZERO;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= sau_pkg::RD_ZERO;
      sfr_hit_o   <= 1'b0;
    end else begin
      sfr_rdata_o <= sfr_rd;
      sfr_hit_o   <= rd_lo || rd_hi;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_r     <= S_IDLE;
      req_r       <= '0;
      core_r      <= '0;
      ptr_r       <= '0;
      ptr_n9_r    <= 1'b0;
      mem_o       <= '0;
      rom_re_o    <= 1'b0;
      rom_addr_o  <= '0;
      res_o       <= '0;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      stack_err_o <= 1'b0;
    end else begin
      mem_o.we    <= 1'b0;
      done_o      <= 1'b0;
      stack_err_o <= 1'b0;
      unique case (state_r)
        S_IDLE: if (take) begin
          req_r  <= req_i;
          core_r <= core_i;
          if (take_psh) begin
            mem_o.we    <= !push_bad;
            mem_o.addr  <= sp_p1;
            mem_o.wdata <= req_i.push_data;
            stack_err_o <= push_bad;
            done_o      <= 1'b1;
          end else if (take_cal) begin
            mem_o.we    <= !push_bad;
            mem_o.addr  <= sp_p1;
            mem_o.wdata <= {req_i.bank, req_i.pc[7:0]};
            stack_err_o <= push_bad;
            busy_o      <= 1'b1;
            state_r     <= S_CALL2;
          end else if (take_pop || take_ret) begin
            mem_o.re    <= 1'b1;
            mem_o.addr  <= sp;
            stack_err_o <= pop_bad;
            busy_o      <= 1'b1;
            state_r     <= take_pop ? S_POP1 : S_RET1;
          end else if (take_ptr) begin
            mem_o.re   <= 1'b1;
            mem_o.addr <= ptr_lo_a;
            busy_o     <= 1'b1;
            state_r    <= S_PTR1;
          end else if (take_now) begin
            res_o.imm   <= imm_v;
            res_o.addr  <= {sau_pkg::RD_ZERO, dir_a};
            res_o.blank <= 1'b0;
            done_o      <= 1'b1;
          end
        end
        S_CALL2: begin
          mem_o.we    <= !push_bad;
          mem_o.addr  <= sp_p1;
          mem_o.wdata <= req_r.pc[16:8];
          stack_err_o <= push_bad;
          busy_o      <= 1'b0;
          done_o      <= 1'b1;
          state_r     <= S_IDLE;
        end
        S_POP1: begin
          mem_o.re <= 1'b0;
          state_r  <= S_POP2;
        end
        S_POP2: begin
          res_o.data <= mem_rdata_i;
          busy_o     <= 1'b0;
          done_o     <= 1'b1;
          state_r    <= S_IDLE;
        end
        S_RET1: begin
          mem_o.addr <= sp_m1;
          state_r    <= S_RET2;
        end
        S_RET2: begin
          mem_o.re            <= 1'b0;
          res_o.ret_pc[16:8]  <= mem_rdata_i;
          state_r             <= S_RET3;
        end
        S_RET3: begin
          res_o.ret_pc[7:0] <= mem_rdata_i[7:0];
          res_o.ret_bank    <= mem_rdata_i[8];
          busy_o            <= 1'b0;
          done_o            <= 1'b1;
          state_r           <= S_IDLE;
        end
        S_PTR1: begin
          mem_o.addr <= ptr_hi_a;
          state_r    <= S_PTR2;
        end
        S_PTR2: begin
          mem_o.re   <= 1'b0;
          ptr_r[7:0] <= mem_rdata_i[7:0];
          state_r    <= S_PTR3;
        end
        S_PTR3: begin
          ptr_r[15:8] <= mem_rdata_i[7:0];
          ptr_n9_r    <= mem_rdata_i[8];
          state_r     <= S_CALC;
        end
        S_CALC: begin
          if (req_r.op == sau_pkg::OP_TABLE) begin
            rom_re_o   <= 1'b1;
            rom_addr_o <= rom_a;
            state_r    <= S_ROM1;
          end else begin
            res_o.addr  <= (req_r.op == sau_pkg::OP_EXT) ?
                           {core_r.breg, sum_a} :
                           {sau_pkg::RD_ZERO, conf_a};
            res_o.blank <= (req_r.op != sau_pkg::OP_EXT) && blank;
            busy_o      <= 1'b0;
            done_o      <= 1'b1;
            state_r     <= S_IDLE;
          end
        end
        S_ROM1: begin
          rom_addr_o[16:0] <= rom_addr_o[16:0] + sau_pkg::ROM_STEP;
          state_r          <= S_ROM2;
        end
        S_ROM2: begin
          rom_re_o      <= 1'b0;
          res_o.tbl_acc <= rom_rdata_i;
          state_r       <= S_ROM3;
        end
        S_ROM3: begin
          res_o.tbl_b <= rom_rdata_i;
          busy_o      <= 1'b0;
          done_o      <= 1'b1;
          state_r     <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_PUSH_PRE_INC: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    take_psh && !push_bad |=> mem_o.we && sp == $past(sp) + 16'h0001
      && mem_o.addr == sp)
    else $error("push did not step pointer before write");

  AST_RET_POST_DEC: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    take_ret |=> ##2 sp == $past(sp, 3) - 16'h0001
      ##1 sp == $past(sp, 4) - 16'h0002 && done_o)
    else $error("return did not step pointer after each read");

  AST_CALL_ORDER: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    take_cal && !push_bad |=> mem_o.we
      && mem_o.wdata == {$past(req_i.bank), $past(req_i.pc[7:0])}
      ##1 mem_o.wdata == req_r.pc[16:8] && mem_o.addr == sp)
    else $error("call bytes out of order");

  AST_CALL_SLOTS: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    take_cal |=> mem_o.addr == $past(sp) + 16'h0001
      ##1 mem_o.addr == $past(sp, 2) + 16'h0002)
    else $error("call slots not at pointer plus one and two");

  AST_PTR_FETCH: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    take_ptr |=> mem_o.re && mem_o.addr == {9'h000, $past(idx), 1'b0}
      ##1 mem_o.re && mem_o.addr[0])
    else $error("pointer bytes fetched from wrong addresses");

  AST_RAM_BLANK: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    state_r == S_CALC && req_r.op == sau_pkg::OP_OPERAND
      && ptr_r <= sau_pkg::RAM_TOP && sum_a > sau_pkg::RAM_TOP
      |=> res_o.blank && done_o)
    else $error("RAM overrun not blanked");

  AST_SFR_WRAP: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    state_r == S_CALC && req_r.op == sau_pkg::OP_OPERAND
      && ptr_r[15:8] == sau_pkg::SFR_PAGE
      |=> res_o.addr[15:8] == sau_pkg::SFR_PAGE && !res_o.blank)
    else $error("register page access left its page");

  AST_TBL_PAIR: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    state_r == S_ROM1 |=> rom_re_o
      && rom_addr_o[16:0] == $past(rom_addr_o[16:0]) + 17'h0_0001
      && rom_addr_o[17] == $past(rom_addr_o[17]))
    else $error("table second byte not at next address");

  AST_TBL_BANK: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    state_r == S_CALC && req_r.op == sau_pkg::OP_TABLE
      |=> rom_addr_o[17] == core_r.tbl_bank
      && (req_r.mode != sau_pkg::MD_PTR
          || rom_addr_o[16:0] == {ptr_n9_r, ptr_r}))
    else $error("table bank flag not applied");

  AST_EXT_TOP: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    state_r == S_CALC && req_r.op == sau_pkg::OP_EXT
      |=> res_o.addr[23:16] == core_r.breg && done_o)
    else $error("external address top byte not from B");

endmodule : sau_top

// *** tb/sau_mem_model.sv ***
/*
 * Data RAM and program ROM model facing the address unit.
 * Assumes reads return data in the cycle after the strobe.
 */
module sau_mem_model (
  input  wire logic              clk_sys_i,
  input  wire sau_pkg::sau_mem_t mem_i,
  input  wire logic              rom_re_i,
  input  wire logic [17:0]       rom_addr_i,
  output logic      [8:0]        mem_rdata_o,
  output logic      [7:0]        rom_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] ram [0:65535];
  logic [8:0] rd_q;
  logic [7:0] rom_q;
  logic       rd_v;
  logic       rom_v;
  // Registered reads and writes; ROM byte is derived from its address
  always @(posedge clk_sys_i) begin
    rd_v  <= mem_i.re;
    rom_v <= rom_re_i;
    if (mem_i.re) rd_q <= ram[mem_i.addr];
    if (mem_i.we) ram[mem_i.addr] <= mem_i.wdata;
    if (rom_re_i) rom_q <= rom_addr_i[7:0] ^ {6'h00, rom_addr_i[17:16]};
  end
  // Released lines show the inverse of the last value
  assign mem_rdata_o = rd_v ? rd_q : ~rd_q;
  assign rom_rdata_o = rom_v ? rom_q : ~rom_q;
endmodule : sau_mem_model

// *** tb/sau_top_test.sv ***
/*
 * Self-checking bench for the stack and operand address unit.
 * Assumes the RAM/ROM model answers the unit's memory strobes.
 */
module sau_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys_i, rstn_i, req_valid_i, sfr_we_i;
  sau_pkg::sau_req_t  req_i;
  sau_pkg::sau_core_t core_i;
  sau_pkg::sau_mem_t  mem_o;
  sau_pkg::sau_res_t  res_o;
  logic [8:0]         mem_rdata_i;
  logic [7:0]         rom_rdata_i, sfr_wdata_i, sfr_rdata_o;
  logic [15:0]        sfr_addr_i;
  logic [17:0]        rom_addr_o;
  logic               rom_re_o, sfr_hit_o, busy_o, done_o, stack_err_o;
  int                 fails, checks_done;
  logic               err_seen = 1'b0;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

  sau_top sau_top_i (.clk_sys_i, .rstn_i, .req_valid_i, .req_i, .core_i,
    .mem_rdata_i, .rom_rdata_i, .sfr_we_i, .sfr_addr_i, .sfr_wdata_i,
    .mem_o, .rom_re_o, .rom_addr_o, .sfr_rdata_o, .sfr_hit_o, .res_o,
    .busy_o, .done_o, .stack_err_o);
  sau_mem_model sau_mem_model_i (.clk_sys_i, .mem_i(mem_o),
    .rom_re_i(rom_re_o), .rom_addr_i(rom_addr_o),
    .mem_rdata_o(mem_rdata_i), .rom_rdata_o(rom_rdata_i));

  // Latch any stack range error pulse
  always @(posedge clk_sys_i)
    if (stack_err_o === 1'b1) err_seen <= 1'b1;

  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask : tick

  // Request held one taking edge, then wait for done
  task automatic run(input sau_pkg::sau_op_t o, input sau_pkg::sau_mode_t m,
                     input logic [5:0] n, input logic [6:0] f,
                     input logic [15:0] d);
    int k = 0;
    req_i = '{o, m, n, f, d, 9'h1A5, 17'h1_2345, 1'b1};
    req_valid_i = 1'b1;
    tick();
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    `CHK("done", 1'b1, done_o)
    `CHK("idle", 1'b0, busy_o)
    // Let one edge pass so writes land before the next request
    tick();
  endtask : run

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_we_i = 1'b1;
    tick();
    sfr_we_i = 1'b0;
    tick();
  endtask : wr

  // Read both stack pointer bytes back
  task automatic rd_sp(input logic [15:0] e);
    sfr_addr_i = sau_pkg::SP_LOW_ADDR;
    tick();
    sfr_addr_i = sau_pkg::SP_HIGH_ADDR;
    `CHK("sp_low", e[7:0], sfr_rdata_o)
    tick();
    `CHK("sp_high", e[15:8], sfr_rdata_o)
    `CHK("sfr_hit", 1'b1, sfr_hit_o)
  endtask : rd_sp

  task automatic ptr(input int n, input logic [8:0] lo, input logic [8:0] hi);
    sau_mem_model_i.ram[2*n] = lo;
    sau_mem_model_i.ram[2*n+1] = hi;
  endtask : ptr

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // Watchdog
  initial begin
    #(40 * 3000);
    fails++;
    complete_run();
  end

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    core_i = '{8'h12, 8'hFF, 1'b1};
    sfr_we_i = 1'b0;
    sfr_addr_i = 16'h0000;
    sfr_wdata_i = 8'h00;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    rd_sp(16'h0000);
    wr(sau_pkg::SP_LOW_ADDR, 8'h10);
    wr(sau_pkg::SP_HIGH_ADDR, 8'h00);
    rd_sp(16'h0010);
    run(sau_pkg::OP_PUSH, sau_pkg::MD_IMM8, 6'h00, 7'h00, 16'h0000);
    `CHK("push", 9'h1A5, sau_mem_model_i.ram[16'h0011])
    run(sau_pkg::OP_CALL, sau_pkg::MD_IMM8, 6'h00, 7'h00, 16'h0000);
    `CHK("call_lo", 9'h145, sau_mem_model_i.ram[16'h0012])
    `CHK("call_hi", 9'h123, sau_mem_model_i.ram[16'h0013])
    rd_sp(16'h0013);
    run(sau_pkg::OP_RET, sau_pkg::MD_IMM8, 6'h00, 7'h00, 16'h0000);
    `CHK("ret_pc", 17'h1_2345, res_o.ret_pc)
    `CHK("ret_bank", 1'b1, res_o.ret_bank)
    run(sau_pkg::OP_POP, sau_pkg::MD_IMM8, 6'h00, 7'h00, 16'h0000);
    `CHK("pop", 9'h1A5, res_o.data)
    rd_sp(16'h0010);
    `CHK("stack_ok", 1'b0, err_seen)
    sau_mem_model_i.ram[16'hFE00] = 9'h0AA;
    wr(sau_pkg::SP_LOW_ADDR, 8'hFF);
    wr(sau_pkg::SP_HIGH_ADDR, 8'hFD);
    run(sau_pkg::OP_PUSH, sau_pkg::MD_IMM8, 6'h00, 7'h00, 16'h0000);
    `CHK("stack_err", 1'b1, err_seen)
    `CHK("no_wr", 9'h0AA, sau_mem_model_i.ram[16'hFE00])
    rd_sp(16'hFE00);
    // Mid-run reset must clear the whole pointer again
    rstn_i = 1'b0;
    tick();
    rstn_i = 1'b1;
    rd_sp(16'h0000);
    $display("test stack done");
    ptr(0, 9'h0FF, 9'h0FD);
    ptr(3, 9'h002, 9'h0FE);
    ptr(5, 9'h056, 9'h034);
    ptr(7, 9'h040, 9'h101);
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_PTR, 6'h03, 7'h00, 16'h0000);
    `CHK("ptr", 16'hFE02, res_o.addr[15:0])
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_PTR_C, 6'h03, 7'h00, 16'h0000);
    `CHK("ptr_c", 16'hFE01, res_o.addr[15:0])
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_OFF, 6'h00, 7'h01, 16'h0000);
    `CHK("ram_over", 1'b1, res_o.blank)
    ptr(0, 9'h0FF, 9'h0FE);
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_OFF, 6'h00, 7'h02, 16'h0000);
    `CHK("page_wrap", 16'hFE01, res_o.addr[15:0])
    `CHK("no_blank", 1'b0, res_o.blank)
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_OFF, 6'h00, 7'h7E, 16'h0000);
    `CHK("off_neg", 16'hFEFD, res_o.addr[15:0])
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_IMM16, 6'h00, 7'h00, 16'h1234);
    `CHK("imm16", 16'h1234, res_o.imm)
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_IMM8, 6'h00, 7'h00, 16'hAB12);
    `CHK("imm8", 16'h0012, res_o.imm)
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_DIRECT, 6'h00, 7'h00, 16'h0123);
    `CHK("direct", 16'hFE23, res_o.addr[15:0])
    run(sau_pkg::OP_OPERAND, sau_pkg::MD_DIRECT_L, 6'h00, 7'h00, 16'h0123);
    `CHK("direct_l", 16'h0123, res_o.addr[15:0])
    run(sau_pkg::OP_EXT, sau_pkg::MD_PTR, 6'h05, 7'h00, 16'h0000);
    `CHK("ext", 24'h12_3456, res_o.addr)
    run(sau_pkg::OP_TABLE, sau_pkg::MD_PTR, 6'h07, 7'h00, 16'h0000);
    `CHK("tbl_acc", 8'h43, res_o.tbl_acc)
    `CHK("tbl_b", 8'h42, res_o.tbl_b)
    core_i = '{8'h12, 8'h01, 1'b0};
    run(sau_pkg::OP_TABLE, sau_pkg::MD_PTR_C, 6'h07, 7'h00, 16'h0000);
    `CHK("tbl0_acc", 8'h40, res_o.tbl_acc)
    `CHK("tbl0_b", 8'h43, res_o.tbl_b)
    $display("test modes done");
    complete_run();
  end
endmodule : sau_top_test
